// ==== verilog/cfg_matrix_pkg.sv ====
// Notes on behaviour
// - por rises last; reference pin leads it
// - falling por disables every pin buffer
// - control bit picks short or long core-reset delay
// - control bit disables automatic supply detection
// - each destination has own 6-bit select
// - shared destinations serve the active cell function
// - pins get data select; most get enable
// - power-down polarity per destination applied
// - two matrix bits pick comparator byte
// - counter keep/up taken from matrix fields
// - two-bit edge block mode decode
// - two-bit delay code, four equal steps
// - output bit selects undelayed or delayed result
// - five-bit reference select per comparator
// - reference ready after selectable wait
// - reference enable, overridden by chip power-down
// - bit picks fast or slow chopper clock
// - bit lets pin 11 steer converter mux
// - pipe delay clock/data/reset from matrix
// - blocks start in fixed order, por last
package cfg_matrix_pkg;
  localparam int CLK_MHZ = 125;
  localparam int VREF_LEAD_US = 3;
  localparam int VREF_LEAD_CYC = VREF_LEAD_US * CLK_MHZ;
  localparam int PAD_SHORT_US = 4;
  localparam int PAD_SHORT_CYC = PAD_SHORT_US * CLK_MHZ;
  localparam int PAD_LONG_US = 500;
  localparam int PAD_LONG_CYC = PAD_LONG_US * CLK_MHZ;
  localparam int REF_SLOW_US = 550;
  localparam int REF_SLOW_CYC = REF_SLOW_US * CLK_MHZ;
  localparam int REF_FAST_US = 100;
  localparam int REF_FAST_CYC = REF_FAST_US * CLK_MHZ;
  localparam int DLY_STEP_NS = 110;
  localparam int STAGE_CYC = 8;
  localparam int CNT_W = 17;
  // register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_EDGE = 12'h004;
  localparam logic [11:0] OFS_VREF = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  localparam logic [11:0] OFS_BYTE0 = 12'h010;
  localparam logic [11:0] OFS_SEL_BASE = 12'h100;
  localparam int SEL_COUNT = 81;
  localparam int BYTE_COUNT = 4;
  // control register fields
  localparam int CTRL_CFG_DONE = 0;
  localparam int CTRL_PAD_LONG = 1;
  localparam int CTRL_DETECT_OFF = 2;
  localparam int CTRL_REF_FAST = 3;
  localparam int CTRL_REF_ON = 4;
  localparam int CTRL_CHOP_SLOW = 5;
  localparam int CTRL_MUX_PIN11 = 6;
  localparam int CTRL_W = 7;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
  localparam logic [4:0] EDGE_RESET = 5'h00;
  localparam logic [9:0] VREF_RESET = 10'h000;
  localparam logic [5:0] SEL_RESET = 6'h00;
  localparam logic [4:0] VREF_FIXED_MAX = 5'h17;
  // matrix destination indices
  localparam int D_PIPE_CLK = 40;
  localparam int D_PIPE_DATA = 41;
  localparam int D_PIPE_RSTN = 42;
  localparam int D_EDGE_IN = 43;
  localparam int D_ADC_PD = 63;
  localparam int D_ACMP0_PDN = 64;
  localparam int D_ACMP1_PDN = 65;
  localparam int D_OSC_PD = 66;
  localparam int D_FSM_KEEP = 71;
  localparam int D_FSM_UP = 72;
  localparam int D_BYTE_SEL0 = 76;
  localparam int D_BYTE_SEL1 = 77;
  localparam int D_PWM_PD = 78;
  localparam int D_SPI_CSN = 79;
  localparam int D_SPI_SCLK = 80;
  localparam int D_STORE2_RSTN = 24;
  localparam int D_STORE2_DATA = 25;
  localparam int D_STORE2_CLK = 26;
  // pins 3,4,5,6,7,9,10,11,12,13,14 in that order
  localparam int PIN_COUNT = 11;
  localparam int NO_OE = 127;
  localparam int PIN_DATA_SEL [PIN_COUNT] = '{44, 46, 48, 50, 51, 53, 55, 56, 57, 59, 61};
  localparam int PIN_OE_SEL [PIN_COUNT] = '{45, 47, 49, NO_OE, 52, 54, NO_OE, NO_OE, 58, 60, 62};

  typedef enum logic [2:0] {
    SEQ_OFF = 3'b000,
    SEQ_INPUTS = 3'b001,
    SEQ_LUTS = 3'b010,
    SEQ_STORE = 3'b011,
    SEQ_LEAD = 3'b100,
    SEQ_ON = 3'b101
  } seq_state_t;

  typedef struct packed {
    logic [PIN_COUNT-1:0] data;
    logic [PIN_COUNT-1:0] oe_n;
  } pin_bus_t;

  typedef struct packed {
    logic adc;
    logic acmp0;
    logic acmp1;
    logic osc;
    logic pwm;
  } pd_bus_t;

  typedef struct packed {
    logic [4:0] acmp0_sel;
    logic [4:0] acmp1_sel;
    logic acmp0_fixed;
    logic acmp1_fixed;
  } vref_bus_t;

  // floor of code+1 steps of 110 ns at the core clock
  function automatic logic [5:0] dly_cycles(input logic [1:0] code);
    int c;
    c = ((int'(code) + 1) * DLY_STEP_NS * CLK_MHZ) / 1000;
    return 6'(c);
  endfunction
endpackage

// ==== verilog/config_matrix.sv ====
// Decided for this implementation: register access over APB and the register addresses.
module config_matrix #(
  parameter int PAD_LONG_CYC = cfg_matrix_pkg::PAD_LONG_CYC,
  parameter int REF_SLOW_CYC = cfg_matrix_pkg::REF_SLOW_CYC,
  parameter int REF_FAST_CYC = cfg_matrix_pkg::REF_FAST_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_ok,
  input wire logic chip_power_down,
  input wire logic pin11_level,
  input wire logic [63:0] matrix_src,
  output logic [80:0] matrix_dest,
  output cfg_matrix_pkg::pin_bus_t pins,
  output cfg_matrix_pkg::pd_bus_t power_down,
  output cfg_matrix_pkg::vref_bus_t vref_sel,
  output logic [7:0] cmp_byte,
  output logic spi_csn,
  output logic spi_sclk,
  output logic fsm_keep,
  output logic fsm_up,
  output logic pipe_clk,
  output logic pipe_data,
  output logic pipe_rstn,
  output logic store2_rstn,
  output logic store2_data,
  output logic store2_clk,
  output logic inputs_en,
  output logic luts_en,
  output logic storage_en,
  output logic core_resetn,
  output logic por,
  output logic vref_out_en,
  output logic ref_ready,
  output logic ref_on,
  output logic chop_slow,
  output logic mux_pin11_ctrl,
  output logic edge_out
);
  logic [cfg_matrix_pkg::CTRL_W-1:0] ctrl;
  logic [4:0] edge_cfg;
  logic [9:0] vref_cfg;
  logic [7:0] byte_reg [cfg_matrix_pkg::BYTE_COUNT];
  logic [5:0] sel [cfg_matrix_pkg::SEL_COUNT];
  logic [1:0] supply_sync;
  logic [1:0] pd_sync;
  logic [1:0] pin11_sync;
  logic supply_seen;
  logic chip_pd;
  cfg_matrix_pkg::seq_state_t state;
  logic [cfg_matrix_pkg::CNT_W-1:0] seq_cnt;
  logic [cfg_matrix_pkg::CNT_W-1:0] ref_cnt;
  logic [cfg_matrix_pkg::CNT_W-1:0] pad_target;
  logic [cfg_matrix_pkg::CNT_W-1:0] ref_target;
  logic wr_en;
  logic rd_en;
  logic sel_hit;
  logic [8:0] sel_idx;
  logic reg_hit;
  logic [31:0] next_rdata;
  logic [1:0] edge_mode;
  logic [5:0] edge_width;
  logic edge_prev;
  logic edge_in;
  logic edge_rise;
  logic edge_fall;
  logic edge_hit;
  logic [5:0] edge_cnt;
  logic [1:0] edge_phase;
  logic edge_held;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  assign pready = 1'b1;
  assign sel_idx = 9'(paddr[10:2] - 9'd64);
  assign sel_hit = paddr[11:8] != 4'h0 && paddr[1:0] == 2'b00
    && paddr < 12'(cfg_matrix_pkg::OFS_SEL_BASE + 4 * cfg_matrix_pkg::SEL_COUNT);

  // input pins cross in through two flops each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_sync <= 2'h0;
      pd_sync <= 2'h0;
      pin11_sync <= 2'h0;
    end else begin
      supply_sync <= {supply_sync[0], supply_ok};
      pd_sync <= {pd_sync[0], chip_power_down};
      pin11_sync <= {pin11_sync[0], pin11_level};
    end
  end
  assign chip_pd = pd_sync[1];
  assign supply_seen = supply_sync[1] || ctrl[cfg_matrix_pkg::CTRL_DETECT_OFF];

  always_comb begin
    reg_hit = 1'b1;
    next_rdata = 32'h0000_0000;
    case (paddr)
      cfg_matrix_pkg::OFS_CTRL: next_rdata = 32'(ctrl);
      cfg_matrix_pkg::OFS_EDGE: next_rdata = 32'(edge_cfg);
      cfg_matrix_pkg::OFS_VREF: next_rdata = 32'(vref_cfg);
      cfg_matrix_pkg::OFS_STATUS:
        next_rdata = {22'h0, ref_on, ref_ready, vref_out_en, core_resetn, por, supply_seen,
          1'b0, state};
      12'h010, 12'h014, 12'h018, 12'h01C: next_rdata = 32'(byte_reg[paddr[3:2]]);
      default: begin
        if (sel_hit) begin
          next_rdata = 32'(sel[sel_idx[6:0]]);
        end else begin
          reg_hit = 1'b0;
        end
      end
    endcase
  end
  assign prdata = rd_en ? next_rdata : 32'h0000_0000;
  assign pslverr = psel && penable && !reg_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= cfg_matrix_pkg::CTRL_RESET;
      edge_cfg <= cfg_matrix_pkg::EDGE_RESET;
      vref_cfg <= cfg_matrix_pkg::VREF_RESET;
    end else if (wr_en) begin
      case (paddr)
        cfg_matrix_pkg::OFS_CTRL: ctrl <= pwdata[cfg_matrix_pkg::CTRL_W-1:0];
        cfg_matrix_pkg::OFS_EDGE: edge_cfg <= pwdata[4:0];
        cfg_matrix_pkg::OFS_VREF: vref_cfg <= pwdata[9:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < cfg_matrix_pkg::BYTE_COUNT; i++) begin
        byte_reg[i] <= 8'h00;
      end
    end else if (wr_en && paddr[11:4] == 8'h01 && paddr[1:0] == 2'b00) begin
      byte_reg[paddr[3:2]] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < cfg_matrix_pkg::SEL_COUNT; i++) begin
        sel[i] <= cfg_matrix_pkg::SEL_RESET;
      end
    end else if (wr_en && sel_hit) begin
      sel[sel_idx[6:0]] <= pwdata[5:0];
    end
  end

  generate
    for (genvar d = 0; d < cfg_matrix_pkg::SEL_COUNT; d++) begin : g_route
      assign matrix_dest[d] = ctrl[cfg_matrix_pkg::CTRL_CFG_DONE] && matrix_src[sel[d]];
    end
  endgenerate

  localparam int CNT_W = cfg_matrix_pkg::CNT_W;
  assign pad_target = ctrl[cfg_matrix_pkg::CTRL_PAD_LONG]
    ? CNT_W'(PAD_LONG_CYC - 1) : CNT_W'(cfg_matrix_pkg::PAD_SHORT_CYC - 1);

  // staged start, por last; lead stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= cfg_matrix_pkg::SEQ_OFF;
      seq_cnt <= '0;
      core_resetn <= 1'b0;
    end else if (!supply_seen) begin
      state <= cfg_matrix_pkg::SEQ_OFF;
      seq_cnt <= '0;
      core_resetn <= 1'b0;
    end else begin
      if (seq_cnt != '0) begin
        seq_cnt <= seq_cnt - 1'b1;
      end
      case (state)
        cfg_matrix_pkg::SEQ_OFF: begin
          if (ctrl[cfg_matrix_pkg::CTRL_CFG_DONE]) begin
            state <= cfg_matrix_pkg::SEQ_INPUTS;
            seq_cnt <= pad_target;
          end
        end
        cfg_matrix_pkg::SEQ_INPUTS: begin
          // pad enable to core reset release
          if (seq_cnt == '0) begin
            core_resetn <= 1'b1;
            state <= cfg_matrix_pkg::SEQ_LUTS;
            seq_cnt <= CNT_W'(cfg_matrix_pkg::STAGE_CYC - 1);
          end
        end
        cfg_matrix_pkg::SEQ_LUTS: begin
          if (seq_cnt == '0) begin
            state <= cfg_matrix_pkg::SEQ_STORE;
            seq_cnt <= CNT_W'(cfg_matrix_pkg::STAGE_CYC - 1);
          end
        end
        cfg_matrix_pkg::SEQ_STORE: begin
          if (seq_cnt == '0) begin
            state <= cfg_matrix_pkg::SEQ_LEAD;
            seq_cnt <= CNT_W'(cfg_matrix_pkg::VREF_LEAD_CYC - 1);
          end
        end
        cfg_matrix_pkg::SEQ_LEAD: begin
          if (seq_cnt == '0) begin
            state <= cfg_matrix_pkg::SEQ_ON;
          end
        end
        cfg_matrix_pkg::SEQ_ON: ;
        default: state <= cfg_matrix_pkg::SEQ_OFF;
      endcase
    end
  end

  assign inputs_en = state != cfg_matrix_pkg::SEQ_OFF;
  assign luts_en = inputs_en && state != cfg_matrix_pkg::SEQ_INPUTS;
  assign storage_en = luts_en && state != cfg_matrix_pkg::SEQ_LUTS;
  assign vref_out_en = state == cfg_matrix_pkg::SEQ_LEAD || state == cfg_matrix_pkg::SEQ_ON;
  assign por = state == cfg_matrix_pkg::SEQ_ON;

  assign ref_target = ctrl[cfg_matrix_pkg::CTRL_REF_FAST]
    ? CNT_W'(REF_FAST_CYC) : CNT_W'(REF_SLOW_CYC);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt <= '0;
      ref_ready <= 1'b0;
    end else if (!core_resetn) begin
      ref_cnt <= '0;
      ref_ready <= 1'b0;
    end else if (ref_cnt < ref_target) begin
      ref_cnt <= ref_cnt + 1'b1;
    end else begin
      ref_ready <= 1'b1;
    end
  end

  // power-down wins over the enable bit
  assign ref_on = ctrl[cfg_matrix_pkg::CTRL_REF_ON] && !chip_pd;
  assign chop_slow = ctrl[cfg_matrix_pkg::CTRL_CHOP_SLOW];
  // pin 11 steers the mux only when enabled
  assign mux_pin11_ctrl = ctrl[cfg_matrix_pkg::CTRL_MUX_PIN11] && pin11_sync[1];

  // reference selects, fixed levels up to 10111
  assign vref_sel.acmp0_sel = vref_cfg[4:0];
  assign vref_sel.acmp1_sel = vref_cfg[9:5];
  assign vref_sel.acmp0_fixed = vref_cfg[4:0] <= cfg_matrix_pkg::VREF_FIXED_MAX;
  assign vref_sel.acmp1_fixed = vref_cfg[9:5] <= cfg_matrix_pkg::VREF_FIXED_MAX;

  // high powers down converter, oscillators, modulators; low powers down comparators
  assign power_down.adc = matrix_dest[cfg_matrix_pkg::D_ADC_PD];
  assign power_down.acmp0 = !matrix_dest[cfg_matrix_pkg::D_ACMP0_PDN];
  assign power_down.acmp1 = !matrix_dest[cfg_matrix_pkg::D_ACMP1_PDN];
  assign power_down.osc = matrix_dest[cfg_matrix_pkg::D_OSC_PD];
  assign power_down.pwm = matrix_dest[cfg_matrix_pkg::D_PWM_PD];
  // serial select and clock from the matrix
  assign spi_csn = matrix_dest[cfg_matrix_pkg::D_SPI_CSN];
  assign spi_sclk = matrix_dest[cfg_matrix_pkg::D_SPI_SCLK];
  assign fsm_keep = matrix_dest[cfg_matrix_pkg::D_FSM_KEEP];
  assign fsm_up = matrix_dest[cfg_matrix_pkg::D_FSM_UP];
  // pipe delay inputs, shared with a table
  assign pipe_clk = matrix_dest[cfg_matrix_pkg::D_PIPE_CLK];
  assign pipe_data = matrix_dest[cfg_matrix_pkg::D_PIPE_DATA];
  assign pipe_rstn = matrix_dest[cfg_matrix_pkg::D_PIPE_RSTN];
  // table inputs reused as storage cell controls
  assign store2_rstn = matrix_dest[cfg_matrix_pkg::D_STORE2_RSTN];
  assign store2_data = matrix_dest[cfg_matrix_pkg::D_STORE2_DATA];
  assign store2_clk = matrix_dest[cfg_matrix_pkg::D_STORE2_CLK];

  // byte pick by two matrix bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_byte <= 8'h00;
    end else begin
      cmp_byte <= byte_reg[{matrix_dest[cfg_matrix_pkg::D_BYTE_SEL1],
        matrix_dest[cfg_matrix_pkg::D_BYTE_SEL0]}];
    end
  end

  // pins; buffers off while por is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins.data <= '0;
      pins.oe_n <= '1;
    end else begin
      for (int p = 0; p < cfg_matrix_pkg::PIN_COUNT; p++) begin
        pins.data[p] <= por && matrix_dest[cfg_matrix_pkg::PIN_DATA_SEL[p]];
        if (cfg_matrix_pkg::PIN_OE_SEL[p] == cfg_matrix_pkg::NO_OE) begin
          pins.oe_n[p] <= !(por && supply_seen);
        end else begin
          pins.oe_n[p] <= !(por && supply_seen
            && matrix_dest[cfg_matrix_pkg::PIN_OE_SEL[p] % 81]);
        end
      end
    end
  end

  // mode decode; delay code to cycles
  assign edge_mode = edge_cfg[1:0];
  assign edge_width = cfg_matrix_pkg::dly_cycles(edge_cfg[3:2]);
  assign edge_in = matrix_dest[cfg_matrix_pkg::D_EDGE_IN];
  assign edge_rise = edge_in && !edge_prev;
  assign edge_fall = !edge_in && edge_prev;
  always_comb begin
    case (edge_mode)
      2'b00: edge_hit = edge_rise;
      2'b01: edge_hit = edge_fall;
      default: edge_hit = edge_rise || edge_fall;
    endcase
  end

  // phase 0 idle, 1 waiting out the delay, 2 pulse high
  // pulse as wide as the delay; optional delay first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_prev <= 1'b0;
      edge_cnt <= 6'h00;
      edge_phase <= 2'h0;
      edge_out <= 1'b0;
      edge_held <= 1'b0;
    end else if (!inputs_en) begin
      edge_prev <= edge_in;
      edge_cnt <= 6'h00;
      edge_phase <= 2'h0;
      edge_out <= 1'b0;
    end else begin
      edge_prev <= edge_in;
      if (edge_hit && edge_mode == 2'b11) begin
        edge_phase <= 2'h1;
        edge_cnt <= edge_width;
        edge_held <= edge_in;
      end else if (edge_hit) begin
        edge_cnt <= edge_width;
        if (edge_cfg[4] && edge_phase != 2'h2) begin
          edge_phase <= 2'h1;
        end else begin
          edge_phase <= 2'h2;
          edge_out <= 1'b1;
        end
      end else if (edge_phase != 2'h0) begin
        edge_cnt <= edge_cnt - 1'b1;
        if (edge_cnt == 6'h01) begin
          if (edge_mode == 2'b11) begin
            edge_out <= edge_held;
            edge_phase <= 2'h0;
          end else if (edge_phase == 2'h1) begin
            edge_phase <= 2'h2;
            edge_cnt <= edge_width;
            edge_out <= 1'b1;
          end else begin
            edge_phase <= 2'h0;
            edge_out <= 1'b0;
          end
        end
      end
    end
  end

  // helper counters read only by the checks below
  logic [8:0] lead_len;
  logic [5:0] pulse_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lead_len <= 9'h000;
      pulse_len <= 6'h00;
    end else begin
      lead_len <= (vref_out_en && !por && lead_len != 9'h1FF) ? lead_len + 1'b1
        : (vref_out_en ? lead_len : 9'h000);
      pulse_len <= edge_out ? ((pulse_len == 6'h3F) ? pulse_len : pulse_len + 1'b1) : 6'h00;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_io_off_por: assert property (!por |=> pins.oe_n == '1)
    else $error("pin driven while por low");
  chk_por_last: assert property ($rose(por) |-> storage_en && luts_en && core_resetn)
    else $error("por rose before all blocks were up");
  chk_vref_lead: assert property ($rose(por) |-> $past(lead_len) >= 9'(cfg_matrix_pkg::VREF_LEAD_CYC - 1))
    else $error("reference pin lead too short");
  chk_core_delay: assert property ($rose(core_resetn) |-> $past(inputs_en, cfg_matrix_pkg::PAD_SHORT_CYC))
    else $error("core reset released too early");
  chk_ref_wait: assert property ($rose(ref_ready) |-> core_resetn && ref_cnt >= ref_target)
    else $error("reference ready before its wait");
  chk_ref_pd: assert property (chip_pd |-> !ref_on)
    else $error("reference on during power down");
  chk_pulse_width: assert property ($fell(edge_out) && edge_mode != 2'b11
    |-> $past(pulse_len) >= edge_width - 6'h01)
    else $error("edge pulse too short");
  chk_edge_rise: assert property (edge_mode == 2'b00 && !edge_cfg[4] && inputs_en
    && edge_rise |=> edge_out)
    else $error("rising edge gave no pulse");
  chk_pin_data: assert property (por && supply_seen |=> pins.data[3] == $past(matrix_dest[50]))
    else $error("pin data does not follow its select");
  chk_byte_pick: assert property (##1 cmp_byte == $past(byte_reg[{matrix_dest[77],
    matrix_dest[76]}]))
    else $error("wrong comparator byte");

  cov_por_up: cover property ($rose(por));
  cov_edge_delayed: cover property (edge_cfg[4] && $rose(edge_out));
  cov_both_delay: cover property (edge_mode == 2'b11 && $changed(edge_out));
  cov_ref_ready: cover property ($rose(ref_ready));
endmodule

// ==== tb/config_matrix_edge_delay_por_bench.sv ====
module config_matrix_edge_delay_por_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic supply_ok = 1'h1;
  logic chip_power_down = 1'h0;
  logic pin11_level = 1'h0;
  logic [63:0] matrix_src = 64'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [80:0] matrix_dest;
  cfg_matrix_pkg::pin_bus_t pins;
  cfg_matrix_pkg::pd_bus_t power_down;
  cfg_matrix_pkg::vref_bus_t vref_sel;
  logic [7:0] cmp_byte;
  logic spi_csn, spi_sclk, fsm_keep, fsm_up, pipe_clk, pipe_data, pipe_rstn;
  logic store2_rstn, store2_data, store2_clk, inputs_en, luts_en, storage_en;
  logic core_resetn, por, vref_out_en, ref_ready, ref_on, chop_slow;
  logic mux_pin11_ctrl, edge_out;
  logic [31:0] rd;
  logic er;
  int error_cnt = 0;
  int comparisons = 0;
  int g, w;
  wire [5:0] st = {ref_ready, por, vref_out_en, storage_en, core_resetn, inputs_en};

  // long counts shortened so the run stays brief
  config_matrix #(.PAD_LONG_CYC(600), .REF_SLOW_CYC(800), .REF_FAST_CYC(300)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .supply_ok, .chip_power_down, .pin11_level, .matrix_src,
    .matrix_dest, .pins, .power_down, .vref_sel, .cmp_byte, .spi_csn, .spi_sclk,
    .fsm_keep, .fsm_up, .pipe_clk, .pipe_data, .pipe_rstn, .store2_rstn,
    .store2_data, .store2_clk, .inputs_en, .luts_en, .storage_en, .core_resetn,
    .por, .vref_out_en, .ref_ready, .ref_on, .chop_slow, .mux_pin11_ctrl,
    .edge_out);

  always #4 pclk = ~pclk;

  // look one step after the edge so registered outputs have landed
  task tick;
    @(posedge pclk);
    #1;
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  function automatic logic [11:0] sa(input int i);
    return cfg_matrix_pkg::OFS_SEL_BASE + 12'(4 * i);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cnt(input int i, input int exp);
    int n;
    n = 0;
    while (st[i] !== 1'h1 && n < 9999) begin
      tick;
      n++;
    end
    chk(n, exp);
  endtask

  task pw;
    g = 0;
    w = 0;
    while (edge_out !== 1'h1 && g < 999) begin
      tick;
      g++;
    end
    while (edge_out === 1'h1 && w < 999) begin
      tick;
      w++;
    end
  endtask

  task toggle;
    @(posedge pclk);
    matrix_src[2] <= ~matrix_src[2];
  endtask

  task t_regs;
    apb(1'h0, cfg_matrix_pkg::OFS_EDGE, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, cfg_matrix_pkg::OFS_VREF, 32'h317);
    apb(1'h0, cfg_matrix_pkg::OFS_VREF, 32'h0);
    chk(rd, 32'h317);
    chk(vref_sel, {5'h17, 5'h18, 1'h1, 1'h0});
    apb(1'h0, 12'h020, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(1'h1, sa(0), 32'h5);
    apb(1'h1, sa(64), 32'h6);
    apb(1'h1, sa(79), 32'h7);
    apb(1'h1, sa(71), 32'h5);
    apb(1'h1, sa(24), 32'h6);
    apb(1'h1, sa(42), 32'h7);
    apb(1'h1, sa(77), 32'h5);
    apb(1'h1, cfg_matrix_pkg::OFS_BYTE0 + 12'h008, 32'hA5);
    @(posedge pclk);
    matrix_src <= 64'hE0;
    tick;
    chk(matrix_dest[0], 1'h0);
  endtask

  task t_seq;
    apb(1'h1, cfg_matrix_pkg::OFS_CTRL, 32'h1);
    while (inputs_en !== 1'h1) tick;
    chk(luts_en, 1'h0);
    cnt(1, 500);
    chk(luts_en, 1'h1);
    cnt(2, 8);
    cnt(3, 8);
    cnt(4, 375);
    tick;
    chk(pins.oe_n & 11'h0C8, 32'h0);
    chk(matrix_dest[0], 1'h1);
    chk(power_down.acmp0, 1'h0);
    chk(spi_csn, 1'h1);
    chk(fsm_keep, 1'h1);
    chk(store2_rstn, 1'h1);
    chk(pipe_rstn, 1'h1);
    chk(cmp_byte, 8'hA5);
    @(posedge pclk);
    matrix_src <= 64'h1;
    tick;
    chk({power_down.adc, power_down.acmp0}, 32'h3);
    chk(cmp_byte, 8'h00);
    chk(store2_rstn, 1'h0);
  endtask

  task t_ctrl;
    @(posedge pclk);
    pin11_level <= 1'h1;
    apb(1'h1, cfg_matrix_pkg::OFS_CTRL, 32'h71);
    repeat (3) tick;
    chk(ref_on, 1'h1);
    chk(chop_slow, 1'h1);
    chk(mux_pin11_ctrl, 1'h1);
    @(posedge pclk);
    chip_power_down <= 1'h1;
    pin11_level <= 1'h0;
    repeat (3) tick;
    chk(ref_on, 1'h0);
    chk(mux_pin11_ctrl, 1'h0);
    apb(1'h1, cfg_matrix_pkg::OFS_CTRL, 32'h1);
    chip_power_down <= 1'h0;
    tick;
    chk(chop_slow, 1'h0);
  endtask

  task t_edge;
    apb(1'h1, sa(43), 32'h2);
    for (int k = 0; k < 4; k++) begin
      apb(1'h1, cfg_matrix_pkg::OFS_EDGE, 32'(k * 4 + k % 2));
      toggle;
      pw;
      chk(g, 1);
      chk(w, (k + 1) * 110 * 125 / 1000);
    end
    apb(1'h1, cfg_matrix_pkg::OFS_EDGE, 32'h12);
    toggle;
    pw;
    chk(g, 14);
    chk(w, 13);
    apb(1'h1, cfg_matrix_pkg::OFS_EDGE, 32'h3);
    toggle;
    repeat (30) tick;
    toggle;
    repeat (12) tick;
    chk(edge_out, 1'h0);
    repeat (32) tick;
    chk(edge_out, 1'h1);
  endtask

  task t_restart;
    @(posedge pclk);
    supply_ok <= 1'h0;
    while (por === 1'h1) tick;
    tick;
    chk(pins.oe_n, 32'h7FF);
    apb(1'h1, cfg_matrix_pkg::OFS_CTRL, 32'h7);
    while (inputs_en !== 1'h1) tick;
    cnt(1, 600);
    cnt(5, 801);
    apb(1'h1, cfg_matrix_pkg::OFS_CTRL, 32'h9);
    tick;
    chk(por, 1'h0);
    @(posedge pclk);
    supply_ok <= 1'h1;
    while (inputs_en !== 1'h1) tick;
    cnt(1, 500);
    cnt(5, 301);
  endtask

  task results;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    results;
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_seq;
    t_ctrl;
    t_edge;
    t_restart;
    results;
  end
endmodule
